/* msp_pkg.sv */
/*
 * Shared constants, types and decode helpers for the two-wire monitor
 * slave port and the bus master that drives it.
 * Assumes a 100 MHz system clock on the master and on the device's user side.
 */
// Functional notes
// - First byte: 7-bit address, then direction bit
// - Address 100 plus two strap pin fields
// - Strap levels resampled on every transaction
// - Device is slave only, never drives clock
// - Accept 400 kHz and 3.4 MHz clocks
// - Words travel most significant byte first
// - Write's first data byte is the pointer
// - Ack address, pointer, two data bytes
// - Master ends write with stop or start
// - Pointer-only write changes no register
// - Read sends high byte, then low byte
// - Master nack or start/stop ends read
// - Pointer persists until next write
// - Master code not acked, enables fast filters
// - Repeated starts keep high-speed mode alive
// - Stop ends high-speed mode
// - 28 ms stall timeout releases the bus
package msp_pkg;

	localparam int CLK_KHZ      = 100000;
	localparam int FAST_KHZ     = 400;
	localparam int HS_KHZ       = 3400;
	// Highest rate gives shortest period, so quarters round up
	localparam int FAST_QUARTER = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);
	localparam int HS_QUARTER   = (CLK_KHZ + 4 * HS_KHZ - 1) / (4 * HS_KHZ);
	localparam int TIMEOUT_MS   = 28;
	localparam int TIMEOUT_CYC  = TIMEOUT_MS * CLK_KHZ;

	localparam logic [2:0] ADDR_BASE      = 3'h4;
	localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
	// Master code id is arbitrary
	localparam logic [2:0] HS_CODE_ID     = 3'h1;
	localparam logic [3:0] BIT_LAST       = 4'h7;
	localparam logic [3:0] BIT_ACK        = 4'h8;

	typedef enum logic [1:0] {STRAP_GND, STRAP_VS, STRAP_SDA, STRAP_SCL} msp_strap_e;

	typedef enum logic [2:0] {
		SL_IDLE, SL_ADDR, SL_PTR, SL_DATA_HI, SL_DATA_LO, SL_RD_HI, SL_RD_LO, SL_IGNORE
	} msp_slave_e;

	typedef enum logic [1:0] {HM_IDLE, HM_START, HM_BIT, HM_STOP} msp_host_e;

	function automatic logic [1:0] strap_bits(input msp_strap_e s);
		unique case (s)
			STRAP_GND: return 2'h0;
			STRAP_VS:  return 2'h1;
			STRAP_SDA: return 2'h2;
			STRAP_SCL: return 2'h3;
		endcase
	endfunction : strap_bits

endpackage : msp_pkg

/* msp_i2c_if.sv */
/*
 * Open-drain two-wire bus joining the master and the monitor slave port.
 * Assumes pull-ups: a line is low only while some enabled driver pulls low.
 */
`timescale 1ns/10ps
interface msp_i2c_if;

	logic scl_host_out;
	logic scl_host_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	assign scl = !(scl_host_oe && !scl_host_out);
	assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

	modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_out, output scl_host_oe,
		output sda_host_out, output sda_host_oe);

endinterface : msp_i2c_if

/* msp_device.sv */
/*
 * Slave end of the monitor's two-wire port: address match from straps,
 * register pointer, word write and word read, high-speed entry, timeout.
 * Assumes the bus clock is the link clock; the user side runs on clock_in
 * and holds rd_data_in steady for the current pointer.
 */
`timescale 1ns/10ps
module msp_device #(
	parameter int TIMEOUT_CYCLES = msp_pkg::TIMEOUT_CYC
) (
	input  wire logic               clock_in,                // System clock
	input  wire logic               rst_n_in,                // Async reset, low
	msp_i2c_if.device               bus,                     // Two-wire bus
	input  wire msp_pkg::msp_strap_e addr_select_low_pin_in,  // Low strap pin
	input  wire msp_pkg::msp_strap_e addr_select_high_pin_in, // High strap pin
	input  wire logic [15:0]        rd_data_in,              // Pointed register
	output logic [7:0]              ptr_out,                 // Register pointer
	output logic [15:0]             wr_data_out,             // Written word
	output logic                    wr_strobe_out,           // Write pulse
	output logic                    hs_mode_out,             // Fast filters on
	output logic                    timeout_out              // Stall abort
);
	import msp_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

	if (TIMEOUT_CYCLES < 2) begin : g_check
		$error("TIMEOUT_CYCLES too small");
	end

	// Start and stop detectors, clocked by the data line itself
	logic start_tog;
	logic next_start_tog;
	logic stop_tog;
	logic next_stop_tog;

	always_comb begin
		next_start_tog = bus.scl ? ~start_tog : start_tog;
		next_stop_tog  = bus.scl ? ~stop_tog : stop_tog;
	end

	always_ff @(negedge bus.sda or negedge rst_n_in) begin
		if (!rst_n_in) begin
			start_tog <= 1'b0;
		end else begin
			start_tog <= next_start_tog;
		end
	end

	always_ff @(posedge bus.sda or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stop_tog <= 1'b0;
		end else begin
			stop_tog <= next_stop_tog;
		end
	end

	// Link-side frame logic on the bus clock
	msp_slave_e  state;
	msp_slave_e  next_state;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [7:0]  sh;
	logic [7:0]  next_sh;
	logic [7:0]  tx;
	logic [7:0]  next_tx;
	logic [15:0] rd_word;
	logic [15:0] next_rd_word;
	logic [7:0]  hi;
	logic [7:0]  next_hi;
	logic [7:0]  ptr;
	logic [7:0]  next_ptr;
	logic [15:0] wdata;
	logic [15:0] next_wdata;
	logic        ack;
	logic        next_ack;
	logic        ptr_tog;
	logic        next_ptr_tog;
	logic        wr_tog;
	logic        next_wr_tog;
	logic        hs_tog;
	logic        next_hs_tog;
	logic        start_seen;
	logic        next_start_seen;
	logic        stop_seen;
	logic        next_stop_seen;
	logic [3:0]  strap_s1;
	logic [3:0]  strap_s2;
	logic [15:0] rd_s1;
	logic [15:0] rd_s2;
	logic [15:0] rd_hold;
	logic [7:0]  byte_in;
	logic [6:0]  my_addr;

	assign byte_in = {sh[6:0], bus.sda};
	// Straps resampled each frame, decoded at the address decision
	assign my_addr = {ADDR_BASE, strap_bits(msp_strap_e'(strap_s2[3:2])),
		strap_bits(msp_strap_e'(strap_s2[1:0]))};

	// Start toggle is stable well before the first rising clock edge
	always_comb begin
		next_state      = state;
		next_cnt        = cnt + 4'h1;
		next_sh         = byte_in;
		next_tx         = tx;
		next_rd_word    = rd_word;
		next_hi         = hi;
		next_ptr        = ptr;
		next_wdata      = wdata;
		next_ack        = 1'b0;
		next_ptr_tog    = ptr_tog;
		next_wr_tog     = wr_tog;
		next_hs_tog     = hs_tog;
		next_start_seen = start_seen;
		next_stop_seen  = stop_seen;
		if (start_tog != start_seen) begin
			next_start_seen = start_tog;
			next_stop_seen  = stop_tog;
			next_state      = SL_ADDR;
			next_cnt        = 4'h1;
		end else if (cnt == BIT_LAST) begin
			unique case (state)
				SL_ADDR: begin
					if (byte_in[7:3] == HS_CODE_PREFIX) begin
						next_hs_tog = ~hs_tog;
						next_state  = SL_IGNORE;
					end else if (byte_in[7:1] == my_addr) begin
						next_ack     = 1'b1;
						next_rd_word = rd_s2;
						next_tx      = rd_s2[15:8];
						next_state   = byte_in[0] ? SL_RD_HI : SL_PTR;
					end else begin
						next_state = SL_IGNORE;
					end
				end
				SL_PTR: begin
					next_ptr     = byte_in;
					next_ptr_tog = ~ptr_tog;
					next_ack     = 1'b1;
					next_state   = SL_DATA_HI;
				end
				SL_DATA_HI: begin
					next_hi    = byte_in;
					next_ack   = 1'b1;
					next_state = SL_DATA_LO;
				end
				SL_DATA_LO: begin
					next_wdata  = {hi, byte_in};
					next_wr_tog = ~wr_tog;
					next_ack    = 1'b1;
					// Extra bytes past one word are left unacknowledged
					next_state  = SL_IGNORE;
				end
				SL_IDLE, SL_RD_HI, SL_RD_LO, SL_IGNORE: begin
				end
			endcase
		end else if (cnt == BIT_ACK) begin
			next_cnt = 4'h0;
			next_sh  = sh;
			// Own address ack is not the master's ack of the high byte
			if (state == SL_RD_HI && !ack) begin
				next_state = bus.sda ? SL_IGNORE : SL_RD_LO;
				next_tx    = rd_word[7:0];
			end else if (state == SL_RD_LO) begin
				// Further acks resend the same word
				next_state = bus.sda ? SL_IGNORE : SL_RD_HI;
				next_tx    = rd_word[15:8];
			end
		end
	end

	always_ff @(posedge bus.scl or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state      <= SL_IDLE;
			cnt        <= 4'h0;
			sh         <= 8'h00;
			tx         <= 8'h00;
			rd_word    <= 16'h0000;
			hi         <= 8'h00;
			ptr        <= 8'h00;
			wdata      <= 16'h0000;
			ack        <= 1'b0;
			ptr_tog    <= 1'b0;
			wr_tog     <= 1'b0;
			hs_tog     <= 1'b0;
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
			strap_s1   <= 4'h0;
			strap_s2   <= 4'h0;
			rd_s1      <= 16'h0000;
			rd_s2      <= 16'h0000;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			sh         <= next_sh;
			tx         <= next_tx;
			rd_word    <= next_rd_word;
			hi         <= next_hi;
			ptr        <= next_ptr;
			wdata      <= next_wdata;
			ack        <= next_ack;
			ptr_tog    <= next_ptr_tog;
			wr_tog     <= next_wr_tog;
			hs_tog     <= next_hs_tog;
			start_seen <= next_start_seen;
			stop_seen  <= next_stop_seen;
			// Raw pin levels; decode only after the second flop
			strap_s1   <= {addr_select_high_pin_in, addr_select_low_pin_in};
			strap_s2   <= strap_s1;
			rd_s1      <= rd_hold;
			rd_s2      <= rd_s1;
		end
	end

	// Data line drive changes only while the clock is low
	logic drv;
	logic next_drv;

	always_comb begin
		next_drv = ack;
		if ((state == SL_RD_HI || state == SL_RD_LO) && cnt <= BIT_LAST) begin
			next_drv = !tx[3'(BIT_LAST - cnt)];
		end
	end

	always_ff @(negedge bus.scl or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drv <= 1'b0;
		end else begin
			drv <= next_drv;
		end
	end

	// Open drain: only ever pulls low; clock line is never driven
	assign bus.sda_dev_out = 1'b0;
	assign bus.sda_dev_oe  = drv && !timeout_out && (stop_tog == stop_seen);

	// User side on the system clock
	logic [5:0]    sy1;
	logic [5:0]    sy2;
	logic [5:0]    sy3;
	logic          e_start;
	logic          e_stop;
	logic          e_hs;
	logic          e_ptr;
	logic          e_wr;
	logic          e_scl;
	logic          busy;
	logic          next_busy;
	logic [TW-1:0] to_cnt;
	logic [TW-1:0] next_to_cnt;
	logic          next_abort;
	logic          next_hs;
	logic [7:0]    next_ptr_out;
	logic [15:0]   next_wr_data;

	assign {e_start, e_stop, e_hs, e_ptr, e_wr, e_scl} = sy2 ^ sy3;

	always_comb begin
		next_busy    = e_start ? 1'b1 : (e_stop ? 1'b0 : busy);
		next_to_cnt  = (!busy || e_scl || timeout_out) ? '0 : to_cnt + 1'b1;
		next_abort   = (to_cnt == TW'(TIMEOUT_CYCLES - 1)) ? 1'b1
			: (e_start ? 1'b0 : timeout_out);
		// A mode entry in the same cycle as a stop wins
		next_hs      = e_hs ? 1'b1 : (e_stop ? 1'b0 : hs_mode_out);
		next_ptr_out = e_ptr ? ptr : ptr_out;
		next_wr_data = e_wr ? wdata : wr_data_out;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sy1           <= 6'h00;
			sy2           <= 6'h00;
			sy3           <= 6'h00;
			busy          <= 1'b0;
			to_cnt        <= '0;
			timeout_out   <= 1'b0;
			hs_mode_out   <= 1'b0;
			ptr_out       <= 8'h00;
			wr_data_out   <= 16'h0000;
			wr_strobe_out <= 1'b0;
			rd_hold       <= 16'h0000;
		end else begin
			sy1           <= {start_tog, stop_tog, hs_tog, ptr_tog, wr_tog, bus.scl};
			sy2           <= sy1;
			sy3           <= sy2;
			busy          <= next_busy;
			to_cnt        <= next_to_cnt;
			timeout_out   <= next_abort;
			hs_mode_out   <= next_hs;
			ptr_out       <= next_ptr_out;
			wr_data_out   <= next_wr_data;
			wr_strobe_out <= e_wr;
			rd_hold       <= rd_data_in;
		end
	end

endmodule : msp_device

/* msp_host.sv */
/*
 * Bus master end: makes the bus clock by division, issues word writes,
 * pointer-only writes and word reads, optionally in high-speed mode.
 * Assumes one command at a time on the user side; no clock stretching.
 */
`timescale 1ns/10ps
module msp_host #(
	parameter int FAST_Q = msp_pkg::FAST_QUARTER,
	parameter int HS_Q   = msp_pkg::HS_QUARTER
) (
	input  wire logic        clock_in,        // System clock
	input  wire logic        rst_n_in,        // Async reset, low
	msp_i2c_if.host          bus,             // Two-wire bus
	input  wire logic        cmd_valid_in,    // Command offered
	output logic             cmd_ready_out,   // Command taken
	input  wire logic        cmd_read_in,     // Read word
	input  wire logic        cmd_ptr_only_in, // Pointer only write
	input  wire logic        cmd_hs_in,       // Use high-speed mode
	input  wire logic [6:0]  cmd_addr_in,     // Slave address
	input  wire logic [7:0]  cmd_ptr_in,      // Pointer value
	input  wire logic [15:0] cmd_wdata_in,    // Write word
	output logic             rsp_valid_out,   // Done pulse
	output logic             rsp_nack_out,    // Slave refused
	output logic [15:0]      rsp_rdata_out    // Read word
);
	import msp_pkg::*;

	if (FAST_Q < 4 || FAST_Q > 256 || HS_Q < 4 || HS_Q > 256) begin : g_check
		$error("Quarter period counts out of range");
	end

	msp_host_e   st;
	msp_host_e   next_st;
	logic [1:0]  ph;
	logic [1:0]  next_ph;
	logic [7:0]  tq;
	logic [7:0]  next_tq;
	logic [3:0]  bitn;
	logic [3:0]  next_bitn;
	logic [1:0]  byten;
	logic [1:0]  next_byten;
	logic [7:0]  sh;
	logic [7:0]  next_sh;
	logic        scl_lvl;
	logic        next_scl_lvl;
	logic        sda_lvl;
	logic        next_sda_lvl;
	logic        hs_pre;
	logic        next_hs_pre;
	logic        in_hs;
	logic        next_in_hs;
	logic        nack;
	logic        next_nack;
	logic        op_rd;
	logic        op_po;
	logic [6:0]  op_addr;
	logic [7:0]  op_ptr;
	logic [15:0] op_wd;
	logic        sda_s1;
	logic        sda_s2;
	logic        tick;
	logic        is_rx;
	logic [1:0]  last;
	logic        take;
	logic [15:0] next_rdata;
	logic        next_rsp;

	function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic pre);
		if (pre) begin
			return {HS_CODE_PREFIX, HS_CODE_ID};
		end
		unique case (idx)
			2'h0: return {op_addr, op_rd};
			2'h1: return op_ptr;
			2'h2: return op_wd[15:8];
			2'h3: return op_wd[7:0];
		endcase
	endfunction : tx_byte

	assign cmd_ready_out = (st == HM_IDLE);
	assign take          = cmd_valid_in && cmd_ready_out;
	assign tick          = (tq == 8'(in_hs ? HS_Q - 1 : FAST_Q - 1));
	assign is_rx         = op_rd && (byten != 2'h0) && !hs_pre;
	assign last          = op_rd ? 2'h2 : (op_po ? 2'h1 : 2'h3);

	always_comb begin
		next_st      = st;
		next_ph      = tick ? ph + 2'h1 : ph;
		next_tq      = (st == HM_IDLE || tick) ? 8'h00 : tq + 8'h01;
		next_bitn    = bitn;
		next_byten   = byten;
		next_sh      = sh;
		next_scl_lvl = scl_lvl;
		next_sda_lvl = sda_lvl;
		next_hs_pre  = hs_pre;
		next_in_hs   = in_hs;
		next_nack    = nack;
		next_rdata   = rsp_rdata_out;
		next_rsp     = 1'b0;
		if (take) begin
			next_st     = HM_START;
			next_ph     = 2'h0;
			next_byten  = 2'h0;
			next_hs_pre = cmd_hs_in;
			next_nack   = 1'b0;
		end else if (tick) begin
			unique case (st)
				HM_IDLE: begin
				end
				HM_START: begin
					unique case (ph)
						2'h0: next_sda_lvl = 1'b1;
						2'h1: next_scl_lvl = 1'b1;
						2'h2: next_sda_lvl = 1'b0;
						2'h3: begin
							next_scl_lvl = 1'b0;
							next_st      = HM_BIT;
							next_bitn    = 4'h0;
							next_sh      = tx_byte(byten, hs_pre);
						end
					endcase
				end
				HM_BIT: begin
					unique case (ph)
						2'h0: begin
							if (bitn == BIT_ACK) begin
								next_sda_lvl = is_rx ? (byten == last) : 1'b1;
							end else begin
								next_sda_lvl = is_rx ? 1'b1 : sh[7];
							end
						end
						2'h1: next_scl_lvl = 1'b1;
						2'h2: begin
							if (bitn == BIT_ACK) begin
								next_nack = !is_rx && sda_s2;
							end else begin
								next_sh = {sh[6:0], sda_s2};
							end
						end
						2'h3: begin
							next_scl_lvl = 1'b0;
							next_bitn    = bitn + 4'h1;
							if (bitn == BIT_ACK) begin
								next_bitn = 4'h0;
								if (is_rx && byten == 2'h1) begin
									next_rdata = {sh, rsp_rdata_out[7:0]};
								end else if (is_rx) begin
									next_rdata = {rsp_rdata_out[15:8], sh};
								end
								if (hs_pre) begin
									next_hs_pre = 1'b0;
									next_in_hs  = 1'b1;
									next_nack   = 1'b0;
									next_st     = HM_START;
								end else if (nack || byten == last) begin
									next_st = HM_STOP;
								end else begin
									next_byten = byten + 2'h1;
									next_sh    = tx_byte(byten + 2'h1, 1'b0);
								end
							end
						end
					endcase
				end
				HM_STOP: begin
					unique case (ph)
						2'h0: next_sda_lvl = 1'b0;
						2'h1: next_scl_lvl = 1'b1;
						2'h2: next_sda_lvl = 1'b1;
						2'h3: begin
							next_st    = HM_IDLE;
							next_in_hs = 1'b0;
							next_rsp   = 1'b1;
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st            <= HM_IDLE;
			ph            <= 2'h0;
			tq            <= 8'h00;
			bitn          <= 4'h0;
			byten         <= 2'h0;
			sh            <= 8'h00;
			scl_lvl       <= 1'b1;
			sda_lvl       <= 1'b1;
			hs_pre        <= 1'b0;
			in_hs         <= 1'b0;
			nack          <= 1'b0;
			op_rd         <= 1'b0;
			op_po         <= 1'b0;
			op_addr       <= 7'h00;
			op_ptr        <= 8'h00;
			op_wd         <= 16'h0000;
			sda_s1        <= 1'b1;
			sda_s2        <= 1'b1;
			rsp_valid_out <= 1'b0;
			rsp_nack_out  <= 1'b0;
			rsp_rdata_out <= 16'h0000;
		end else begin
			st            <= next_st;
			ph            <= next_ph;
			tq            <= next_tq;
			bitn          <= next_bitn;
			byten         <= next_byten;
			sh            <= next_sh;
			scl_lvl       <= next_scl_lvl;
			sda_lvl       <= next_sda_lvl;
			hs_pre        <= next_hs_pre;
			in_hs         <= next_in_hs;
			nack          <= next_nack;
			sda_s1        <= bus.sda;
			sda_s2        <= sda_s1;
			rsp_valid_out <= next_rsp;
			rsp_nack_out  <= next_rsp ? nack : rsp_nack_out;
			rsp_rdata_out <= next_rdata;
			if (take) begin
				op_rd   <= cmd_read_in;
				op_po   <= cmd_ptr_only_in;
				op_addr <= cmd_addr_in;
				op_ptr  <= cmd_ptr_in;
				op_wd   <= cmd_wdata_in;
			end
		end
	end

	assign bus.scl_host_out = 1'b0;
	assign bus.scl_host_oe  = !scl_lvl;
	assign bus.sda_host_out = 1'b0;
	assign bus.sda_host_oe  = !sda_lvl;

endmodule : msp_host

/* msp_bus_monitor.sv */
/*
 * Concurrent checks on the two-wire bus between master and slave port.
 * Assumes the lines are sampled by clock_in, far faster than the bus clock.
 */
`timescale 1ns/10ps
module msp_bus_monitor #(
	parameter int SCL_Q = 12
) (
	input  wire logic clock_in,    // System clock
	input  wire logic rst_n_in,    // Async reset, low
	input  wire logic scl_host_oe, // Master pulls clock
	input  wire logic sda_host_oe, // Master pulls data
	input  wire logic sda_dev_oe,  // Slave pulls data
	input  wire logic scl,         // Resolved clock line
	input  wire logic sda          // Resolved data line
);
	localparam logic [7:0] STILL_MAX = 8'(4 * SCL_Q);
	logic       scl_q;
	logic       sda_q;
	logic       busy;
	logic       next_busy;
	logic [5:0] rise_cnt;
	logic [5:0] next_rise_cnt;
	logic [7:0] first_byte;
	logic [7:0] next_first_byte;
	logic [7:0] still_cnt;
	logic [7:0] next_still_cnt;

	always_comb begin
		next_busy       = busy;
		next_rise_cnt   = rise_cnt;
		next_first_byte = first_byte;
		next_still_cnt  = (scl == scl_q && still_cnt != 8'hff) ? still_cnt + 8'h01 : 8'h00;
		if (scl && !scl_q) begin
			next_rise_cnt = (rise_cnt == 6'h3f) ? rise_cnt : rise_cnt + 6'h01;
			if (rise_cnt < 6'h08)
				next_first_byte = {first_byte[6:0], sda};
		end
		// Start restarts the bit count, repeated start included
		if (scl && scl_q && sda_q && !sda) begin
			next_busy      = 1'b1;
			next_rise_cnt  = 6'h00;
			next_still_cnt = 8'h00;
		end
		if (scl && scl_q && !sda_q && sda)
			next_busy = 1'b0;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			busy       <= 1'b0;
			rise_cnt   <= 6'h00;
			first_byte <= 8'h00;
			still_cnt  <= 8'h00;
		end else begin
			scl_q      <= scl;
			sda_q      <= sda;
			busy       <= next_busy;
			rise_cnt   <= next_rise_cnt;
			first_byte <= next_first_byte;
			still_cnt  <= next_still_cnt;
		end
	end

	default clocking mon_cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	sequence rise_s;
		scl && !scl_q;
	endsequence
	sequence write_slot_s;
		first_byte[0] == 1'b0 && rise_cnt >= 6'h08;
	endsequence

	dev_edge_low_a: assert property ($rose(sda_dev_oe) |-> !scl)
		else $error("slave pulled data while clock high");
	idle_clock_high_a: assert property (!busy |-> scl)
		else $error("clock held low outside a frame");
	addr_quiet_a: assert property (busy && rise_cnt < 6'h08 |-> !sda_dev_oe)
		else $error("slave drove data during address bits");
	stop_release_a: assert property (!busy |-> !sda_dev_oe)
		else $error("slave holds data after stop");
	clock_alive_a: assert property (busy |-> still_cnt < STILL_MAX)
		else $error("bus clock stalled inside a frame");
	hs_code_nack_a: assert property (
		rise_s ##0 (rise_cnt == 6'h08 && first_byte[7:3] == 5'h01) |-> sda)
		else $error("master code was acknowledged");
	write_ack_only_a: assert property (rise_s ##0 write_slot_s ##0
		(rise_cnt != 6'h08 && rise_cnt != 6'h11 && rise_cnt != 6'h1a && rise_cnt != 6'h23)
		|-> !sda_dev_oe)
		else $error("slave drove data outside an ack slot");
	read_master_ack_a: assert property (
		rise_s ##0 (first_byte[0] && rise_cnt == 6'h11) |-> !sda_dev_oe)
		else $error("slave drove the master ack slot");
	host_idle_release_a: assert property (!busy |-> !scl_host_oe)
		else $error("master pulls clock outside a frame");
	host_rx_release_a: assert property (
		rise_s ##0 (first_byte[0] && rise_cnt >= 6'h0a && rise_cnt <= 6'h10) |-> !sda_host_oe)
		else $error("master drove data during a read byte");

endmodule : msp_bus_monitor

/* monitor_i2c_slave_port_test.sv */
/*
 * Self-checking bench: master end and slave port joined on one bus.
 * Assumes the master makes the bus clock; no stall is injected.
 */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module monitor_i2c_slave_port_test;
	import msp_pkg::*;
	logic        clock_in        = 1'b0;
	logic        rst_n_in        = 1'b0;
	logic        cmd_valid_in    = 1'b0;
	logic        cmd_read_in     = 1'b0;
	logic        cmd_ptr_only_in = 1'b0;
	logic        cmd_hs_in       = 1'b0;
	logic [6:0]  cmd_addr_in     = 7'h40;
	logic [7:0]  cmd_ptr_in      = 8'h00;
	logic [15:0] cmd_wdata_in    = 16'h0000;
	msp_strap_e  sel_lo          = STRAP_GND;
	msp_strap_e  sel_hi          = STRAP_GND;
	logic        cmd_ready_out, rsp_valid_out, rsp_nack_out;
	logic        wr_strobe_out, hs_mode_out, timeout_out, hs_seen;
	logic [15:0] rsp_rdata_out, wr_data_out, rd_data_in;
	logic [7:0]  ptr_out;
	logic [36:0] wire_bits;
	logic        scl_q           = 1'b1;
	int          fail_count      = 0;
	int          comparisons     = 0;
	int          strobes         = 0;

	msp_i2c_if bus_if();
	msp_host #(.FAST_Q(12), .HS_Q(4)) msp_host_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.bus(bus_if), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
		.cmd_read_in(cmd_read_in), .cmd_ptr_only_in(cmd_ptr_only_in), .cmd_hs_in(cmd_hs_in),
		.cmd_addr_in(cmd_addr_in), .cmd_ptr_in(cmd_ptr_in), .cmd_wdata_in(cmd_wdata_in),
		.rsp_valid_out(rsp_valid_out), .rsp_nack_out(rsp_nack_out),
		.rsp_rdata_out(rsp_rdata_out));
	// Short timeout keeps a stalled run brief
	msp_device #(.TIMEOUT_CYCLES(2000)) msp_device_i (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .bus(bus_if), .addr_select_low_pin_in(sel_lo),
		.addr_select_high_pin_in(sel_hi), .rd_data_in(rd_data_in), .ptr_out(ptr_out),
		.wr_data_out(wr_data_out), .wr_strobe_out(wr_strobe_out), .hs_mode_out(hs_mode_out),
		.timeout_out(timeout_out));
	msp_bus_monitor #(.SCL_Q(12)) msp_bus_monitor_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.scl_host_oe(bus_if.scl_host_oe), .sda_host_oe(bus_if.sda_host_oe),
		.sda_dev_oe(bus_if.sda_dev_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	// Register file stand-in: content derived from the pointer
	assign rd_data_in = {~ptr_out, ptr_out};
	always #5 clock_in = ~clock_in;

	always @(posedge clock_in) begin
		scl_q <= bus_if.scl;
		if (wr_strobe_out === 1'b1)
			strobes <= strobes + 1;
		if (bus_if.scl && !scl_q)
			wire_bits <= {wire_bits[35:0], bus_if.sda};
	end

	task automatic complete_run();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task automatic xfer(input logic rd, input logic po, input logic hs, input logic [6:0] addr,
		input logic [7:0] ptr, input logic [15:0] wd);
		int i;
		@(posedge clock_in);
		#1;
		{cmd_read_in, cmd_ptr_only_in, cmd_hs_in} = {rd, po, hs};
		cmd_addr_in = addr;
		cmd_ptr_in = ptr;
		cmd_wdata_in = wd;
		cmd_valid_in = 1'b1;
		hs_seen = 1'b0;
		@(posedge clock_in);
		#1;
		cmd_valid_in = 1'b0;
		for (i = 0; i < 30000 && rsp_valid_out !== 1'b1; i++) begin
			@(posedge clock_in);
			#1;
			if (hs_mode_out === 1'b1)
				hs_seen = 1'b1;
		end
		if (i == 30000) begin
			fail_count++;
			complete_run();
		end
	endtask : xfer

	function automatic logic [6:0] own_addr();
		return {ADDR_BASE, 2'(sel_hi), 2'(sel_lo)};
	endfunction : own_addr

	task automatic t_straps();
		int base;
		base = strobes;
		for (int i = 0; i < 16; i++) begin
			sel_lo = msp_strap_e'(i[1:0]);
			sel_hi = msp_strap_e'(i[3:2]);
			xfer(1'b0, 1'b1, 1'b0, own_addr(), 8'(i) + 8'h10, 16'h0000);
			`CHK("own nack", 1'b0, rsp_nack_out)
			`CHK("pointer", 8'(i) + 8'h10, ptr_out)
			xfer(1'b0, 1'b1, 1'b0, own_addr() ^ 7'h01, 8'hee, 16'h0000);
			`CHK("foreign nack", 1'b1, rsp_nack_out)
			`CHK("pointer kept", 8'(i) + 8'h10, ptr_out)
		end
		`CHK("no strobe", base, strobes)
	endtask : t_straps

	task automatic t_write();
		int base;
		base = strobes;
		xfer(1'b0, 1'b0, 1'b0, own_addr(), 8'h05, 16'ha5c3);
		`CHK("write nack", 1'b0, rsp_nack_out)
		`CHK("word", 16'ha5c3, wr_data_out)
		// Bit 0 is the clock rise inside the stop condition
		`CHK("wire", {own_addr(), 2'b00, 8'h05, 1'b0, 8'ha5, 1'b0, 8'hc3, 1'b0}, wire_bits[36:1])
		xfer(1'b0, 1'b0, 1'b0, own_addr(), 8'h06, 16'h3c5a);
		`CHK("second word", 16'h3c5a, wr_data_out)
		`CHK("second pointer", 8'h06, ptr_out)
		`CHK("strobes", base + 2, strobes)
	endtask : t_write

	task automatic t_read();
		xfer(1'b0, 1'b1, 1'b0, own_addr(), 8'h07, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, 1'b0, 1'b0, own_addr(), 8'h00, 16'h0000);
			`CHK("read word", {8'hf8, 8'h07}, rsp_rdata_out)
			`CHK("read wire", {own_addr(), 2'b10, 8'hf8, 1'b0, 8'h07, 1'b1}, wire_bits[27:1])
			`CHK("read pointer", 8'h07, ptr_out)
		end
	endtask : t_read

	task automatic t_hs();
		xfer(1'b0, 1'b0, 1'b1, own_addr(), 8'h09, 16'h0ff0);
		`CHK("hs nack", 1'b0, rsp_nack_out)
		`CHK("hs entered", 1'b1, hs_seen)
		`CHK("hs word", 16'h0ff0, wr_data_out)
		`CHK("hs left", 1'b0, hs_mode_out)
		`CHK("no stall", 1'b0, timeout_out)
	endtask : t_hs

	initial begin
		repeat (20) @(posedge clock_in);
		#1;
		rst_n_in = 1'b1;
		t_straps();
		t_write();
		t_read();
		t_hs();
		complete_run();
	end

endmodule : monitor_i2c_slave_port_test
